// file: core/pot_link_pkg.sv
// Purpose: shared constants for the single-wire potentiometer slave
// Assumes: 125 MHz system clock
// Notes: times in microseconds, cycle counts derived
package pot_link_pkg;
   localparam int CLK_KHZ = 125000;
   // line timing in microseconds, regular and fast speed
   localparam int RESET_LOW_US = 480;
   localparam int RESET_LOW_FAST_US = 48;
   localparam int EXIT_FAST_US = 480;
   localparam int PWAIT_US = 30;
   localparam int PWAIT_FAST_US = 3;
   localparam int PLOW_US = 120;
   localparam int PLOW_FAST_US = 12;
   localparam int SLOT_US = 30;
   localparam int SLOT_FAST_US = 3;
   // least times, rounded up to whole cycles
   function automatic int us_to_cyc(input int us);
      return (us * CLK_KHZ + 999) / 1000;
   endfunction
   // rom commands
   localparam logic [7:0] ROM_SKIP = 8'hcc;
   localparam logic [7:0] ROM_FAST_SKIP = 8'h3c;
   localparam logic [7:0] ROM_MATCH = 8'h55;
   localparam logic [7:0] ROM_FAST_MATCH = 8'h69;
   localparam logic [7:0] ROM_SEARCH = 8'hf0;
   localparam logic [7:0] ROM_COND_SEARCH = 8'hec;
   localparam logic [7:0] ROM_RESUME = 8'ha5;
   // potentiometer commands
   localparam logic [7:0] FN_WRITE_CTL = 8'h55;
   localparam logic [7:0] FN_WRITE_POS = 8'h0f;
   localparam logic [7:0] FN_RELEASE = 8'h96;
   localparam logic [7:0] FN_INC = 8'hc3;
   localparam logic [7:0] FN_DEC = 8'h99;
   // control byte fields and reset values
   localparam int WIPER_NUMBER_LSB = 0;
   localparam int WIPER_NUMBER_W = 2;
   localparam int CHARGE_PUMP_BIT = 6;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] WIPER_RESET = 8'h00;
   localparam logic [7:0] WIPER_MAX = 8'hff;
   localparam int FIFO_DEPTH = 8;
endpackage

// file: core/single_wire_pot_slave.sv
// Purpose: slave logic of a single-wire open-drain potentiometer link
// Assumes: line is a pin, synchronised here; master keeps its own timing
// Notes: committed wiper positions queue in a small fifo for the user side
`timescale 1ns/100ps
module pot_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // fill side
   input wire logic i_valid,
   input wire logic [WIDTH-1:0] i_data,
   output logic o_ready,
   // drain side
   output logic o_valid,
   output logic [WIDTH-1:0] o_data,
   input wire logic i_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr;
   logic [AW-1:0] rd;
   logic [AW:0] count;
   logic push;
   logic pop;
   // the head register is one of the DEPTH words, so it counts toward full
   assign o_ready = ((count + (AW+1)'(o_valid)) != (AW+1)'(DEPTH));
   assign push = i_valid && o_ready;
   // head register keeps the drain outputs straight from flops
   assign pop = (count != '0) && (!o_valid || i_ready);
   always_ff @(posedge i_clock) begin
      if (push) begin
         mem[wr] <= i_data;
      end
   end
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         wr <= '0;
         rd <= '0;
         count <= '0;
      end else begin
         if (push) wr <= wr + 1'b1;
         if (pop) rd <= rd + 1'b1;
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_valid <= 1'b0;
         o_data <= '0;
      end else if (pop) begin
         o_valid <= 1'b1;
         o_data <= mem[rd];
      end else if (i_ready) begin
         o_valid <= 1'b0;
      end
   end
endmodule

module single_wire_pot_slave #(
   parameter logic [63:0] ROM_ID = 64'h0123_4567_89ab_cd5a, // arbitrary value
   parameter int RST_CYC = pot_link_pkg::us_to_cyc(pot_link_pkg::RESET_LOW_US),
   parameter int RST_FAST_CYC = pot_link_pkg::us_to_cyc(pot_link_pkg::RESET_LOW_FAST_US),
   parameter int EXIT_CYC = pot_link_pkg::us_to_cyc(pot_link_pkg::EXIT_FAST_US),
   parameter int PWAIT_CYC = pot_link_pkg::us_to_cyc(pot_link_pkg::PWAIT_US),
   parameter int PWAIT_FAST_CYC = pot_link_pkg::us_to_cyc(pot_link_pkg::PWAIT_FAST_US),
   parameter int PLOW_CYC = pot_link_pkg::us_to_cyc(pot_link_pkg::PLOW_US),
   parameter int PLOW_FAST_CYC = pot_link_pkg::us_to_cyc(pot_link_pkg::PLOW_FAST_US),
   parameter int SLOT_CYC = pot_link_pkg::us_to_cyc(pot_link_pkg::SLOT_US),
   parameter int SLOT_FAST_CYC = pot_link_pkg::us_to_cyc(pot_link_pkg::SLOT_FAST_US)
) (
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // open-drain line
   input wire logic i_line,
   output logic o_line_out,
   output logic o_line_oe_n,
   // potentiometer state
   output logic [7:0] o_wiper,
   output logic [7:0] o_control,
   output logic [1:0] o_wiper_number_field,
   output logic o_charge_pump_on_bit,
   output logic o_fast_mode,
   output logic o_resume_select_flag,
   // committed positions
   output logic o_pos_valid,
   output logic [7:0] o_pos_data,
   input wire logic i_pos_ready
);
   typedef enum logic [3:0] {L_IDLE = 4'h1, L_PWAIT = 4'h2, L_PLOW = 4'h4, L_SLOT = 4'h8} link_t;
   typedef enum logic [9:0] {
      P_ROM = 10'h001, P_MATCH = 10'h002, P_SEARCH = 10'h004, P_FUNC = 10'h008, P_RXDATA = 10'h010,
      P_ECHO = 10'h020, P_RXREL = 10'h040, P_STATUS = 10'h080, P_TXPOS = 10'h100, P_WAIT = 10'h200
   } proto_t;
   link_t link;
   proto_t state;
   logic s1, s2, s2_d;
   logic fall, rise;
   logic [19:0] low_cnt;
   logic [19:0] t;
   logic drive;
   logic rst_det;
   logic slot_done;
   logic rx_bit;
   logic [7:0] sh;
   logic [2:0] bcnt;
   logic byte_done;
   logic [7:0] rx_byte;
   logic [7:0] tx_sh;
   logic [5:0] idx;
   logic [1:0] phase;
   logic tx_mode;
   logic tx_bit;
   logic status_bit;
   logic pend_ctl;
   logic [7:0] pend;
   logic set_fast;
   logic flag_set;
   logic flag_clr;
   logic push;
   logic fifo_ready;
   logic [19:0] rst_lim, pwait_lim, plow_lim, slot_lim;

   // two flops before the line is read
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         s1 <= 1'b1;
         s2 <= 1'b1;
         s2_d <= 1'b1;
      end else begin
         s1 <= i_line;
         s2 <= s1;
         s2_d <= s2;
      end
   end
   assign fall = s2_d && !s2;
   assign rise = !s2_d && s2;
   assign rst_lim = o_fast_mode ? 20'(RST_FAST_CYC) : 20'(RST_CYC);
   assign pwait_lim = o_fast_mode ? 20'(PWAIT_FAST_CYC) : 20'(PWAIT_CYC);
   assign plow_lim = o_fast_mode ? 20'(PLOW_FAST_CYC) : 20'(PLOW_CYC);
   assign slot_lim = o_fast_mode ? 20'(SLOT_FAST_CYC) : 20'(SLOT_CYC);
   assign rst_det = rise && (low_cnt >= rst_lim);

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         low_cnt <= '0;
      end else if (fall) begin
         low_cnt <= 20'd1;
      end else if (!s2 && low_cnt != '1) begin
         low_cnt <= low_cnt + 1'b1;
      end
   end

   // link timing; a long low overrides any slot in progress
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         link <= L_IDLE;
         t <= '0;
         drive <= 1'b0;
         rx_bit <= 1'b1;
      end else if (rst_det) begin
         link <= L_PWAIT;
         t <= '0;
         drive <= 1'b0;
      end else begin
         case (link)
            L_IDLE: begin
               if (fall) begin
                  link <= L_SLOT;
                  t <= '0;
                  drive <= tx_mode && !tx_bit;
               end
            end
            L_PWAIT: begin
               t <= t + 1'b1;
               if (t >= pwait_lim - 1'b1) begin
                  link <= L_PLOW;
                  t <= '0;
                  drive <= 1'b1;
               end
            end
            L_PLOW: begin
               t <= t + 1'b1;
               if (t >= plow_lim - 1'b1) begin
                  link <= L_IDLE;
                  drive <= 1'b0;
               end
            end
            L_SLOT: begin
               t <= t + 1'b1;
               if (t >= slot_lim - 1'b1) begin
                  link <= L_IDLE;
                  drive <= 1'b0;
                  rx_bit <= s2;
               end
            end
            default: link <= L_IDLE;
         endcase
      end
   end
   assign slot_done = (link == L_SLOT) && (t >= slot_lim - 1'b1) && !rst_det;

   // only presence and read zeros drive
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_line_out <= 1'b0;
         o_line_oe_n <= 1'b1;
      end else begin
         o_line_out <= 1'b0;
         o_line_oe_n <= !drive;
      end
   end

   // lsb first, eight slots a byte
   assign rx_byte = {s2, sh[7:1]};
   assign byte_done = slot_done && (bcnt == 3'd7) && (state != P_SEARCH);
   assign tx_mode = (state == P_ECHO) || (state == P_STATUS) || (state == P_TXPOS) ||
                    ((state == P_SEARCH) && (phase != 2'd2));
   assign tx_bit = (state == P_SEARCH) ? (ROM_ID[idx] ^ phase[0]) :
                   (state == P_STATUS) ? status_bit : tx_sh[0];

   // long reset exits, short keeps fast
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_fast_mode <= 1'b0;
      end else if (set_fast) begin
         o_fast_mode <= 1'b1;
      end else if (rst_det && low_cnt >= 20'(EXIT_CYC)) begin
         o_fast_mode <= 1'b0;
      end
   end

   // set wins over clear
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_resume_select_flag <= 1'b0;
      end else if (flag_set) begin
         o_resume_select_flag <= 1'b1;
      end else if (flag_clr) begin
         o_resume_select_flag <= 1'b0;
      end
   end

   assign set_fast = byte_done && (state == P_ROM) &&
                     (rx_byte == pot_link_pkg::ROM_FAST_SKIP || rx_byte == pot_link_pkg::ROM_FAST_MATCH);
   // matched id or finished search
   // bit counter is frozen during id bits, so only the id index marks the end
   assign flag_set = slot_done && idx == 6'd63 && s2 == ROM_ID[63] &&
                     (state == P_MATCH || (state == P_SEARCH && phase == 2'd2));
   assign flag_clr = slot_done && s2 != ROM_ID[idx] &&
                     (state == P_MATCH || (state == P_SEARCH && phase == 2'd2));
   assign push = slot_done && bcnt == 3'd7 && state == P_RXREL && !pend_ctl &&
                 rx_byte == pot_link_pkg::FN_RELEASE && fifo_ready;

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         state <= P_WAIT;
         sh <= '0;
         bcnt <= '0;
         tx_sh <= '0;
         idx <= '0;
         phase <= '0;
         status_bit <= 1'b1;
         pend_ctl <= 1'b0;
         pend <= '0;
         o_wiper <= pot_link_pkg::WIPER_RESET;
         o_control <= pot_link_pkg::CONTROL_RESET;
         o_wiper_number_field <= '0;
         o_charge_pump_on_bit <= 1'b0;
      end else if (rst_det) begin
         state <= P_ROM;
         bcnt <= '0;
         idx <= '0;
         phase <= '0;
      end else if (slot_done) begin
         sh <= rx_byte;
         tx_sh <= {1'b1, tx_sh[7:1]};
         if (state != P_SEARCH && state != P_MATCH) bcnt <= bcnt + 1'b1;
         case (state)
            P_ROM: begin
               if (bcnt == 3'd7) begin
                  case (rx_byte)
                     pot_link_pkg::ROM_SKIP, pot_link_pkg::ROM_FAST_SKIP: state <= P_FUNC;
                     pot_link_pkg::ROM_MATCH, pot_link_pkg::ROM_FAST_MATCH: state <= P_MATCH;
                     pot_link_pkg::ROM_SEARCH: state <= P_SEARCH;
                     pot_link_pkg::ROM_COND_SEARCH: state <= (o_wiper == 8'h00) ? P_SEARCH : P_WAIT;
                     pot_link_pkg::ROM_RESUME: state <= o_resume_select_flag ? P_FUNC : P_WAIT;
                     default: state <= P_WAIT;
                  endcase
               end
            end
            P_MATCH: begin
               idx <= idx + 1'b1;
               if (s2 != ROM_ID[idx]) state <= P_WAIT;
               else if (idx == 6'd63) state <= P_FUNC;
            end
            P_SEARCH: begin
               phase <= (phase == 2'd2) ? 2'd0 : phase + 1'b1;
               if (phase == 2'd2) begin
                  idx <= idx + 1'b1;
                  if (s2 != ROM_ID[idx]) state <= P_WAIT;
                  else if (idx == 6'd63) state <= P_FUNC;
               end
            end
            P_FUNC: begin
               if (bcnt == 3'd7) begin
                  case (rx_byte)
                     pot_link_pkg::FN_WRITE_CTL, pot_link_pkg::FN_WRITE_POS: begin
                        pend_ctl <= (rx_byte == pot_link_pkg::FN_WRITE_CTL);
                        state <= P_RXDATA;
                     end
                     pot_link_pkg::FN_INC: begin
                        if (o_wiper != pot_link_pkg::WIPER_MAX) o_wiper <= o_wiper + 1'b1;
                        tx_sh <= (o_wiper != pot_link_pkg::WIPER_MAX) ? o_wiper + 1'b1 : o_wiper;
                        state <= P_TXPOS;
                     end
                     pot_link_pkg::FN_DEC: begin
                        if (o_wiper != 8'h00) o_wiper <= o_wiper - 1'b1;
                        tx_sh <= (o_wiper != 8'h00) ? o_wiper - 1'b1 : o_wiper;
                        state <= P_TXPOS;
                     end
                     default: state <= P_WAIT;
                  endcase
               end
            end
            P_RXDATA: begin
               if (bcnt == 3'd7) begin
                  pend <= rx_byte;
                  tx_sh <= rx_byte;
                  state <= P_ECHO;
               end
            end
            P_ECHO: begin
               if (bcnt == 3'd7) state <= P_RXREL;
            end
            P_RXREL: begin
               // commit on release code; a full queue fails a position write, not a control write
               if (bcnt == 3'd7) begin
                  state <= P_STATUS;
                  status_bit <= 1'b1;
                  if (rx_byte == pot_link_pkg::FN_RELEASE && (pend_ctl || fifo_ready)) begin
                     status_bit <= 1'b0;
                     if (pend_ctl) begin
                        o_control <= pend;
                        o_wiper_number_field <= pend[pot_link_pkg::WIPER_NUMBER_LSB +: pot_link_pkg::WIPER_NUMBER_W];
                        o_charge_pump_on_bit <= pend[pot_link_pkg::CHARGE_PUMP_BIT];
                     end else begin
                        o_wiper <= pend;
                     end
                  end
               end
            end
            P_TXPOS: begin
               if (bcnt == 3'd7) state <= P_FUNC;
            end
            P_STATUS: state <= P_STATUS;
            default: state <= P_WAIT;
         endcase
      end
   end

   pot_fifo #(.WIDTH(8), .DEPTH(pot_link_pkg::FIFO_DEPTH)) u_fifo (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_valid(push),
      .i_data(pend),
      .o_ready(fifo_ready),
      .o_valid(o_pos_valid),
      .o_data(o_pos_data),
      .i_ready(i_pos_ready)
   );

   chk_resume_enter: assert property (@(posedge i_clock) disable iff (i_rst)
      (byte_done && state == P_ROM && rx_byte == pot_link_pkg::ROM_RESUME && o_resume_select_flag)
      |=> state == P_FUNC) else $error("resume did not enter commands");
   chk_resume_set: assert property (@(posedge i_clock) disable iff (i_rst)
      $rose(o_resume_select_flag) |-> $past(state == P_MATCH || state == P_SEARCH))
      else $error("resume flag set outside selection");
   chk_resume_hold: assert property (@(posedge i_clock) disable iff (i_rst)
      (o_resume_select_flag && !flag_clr) |=> o_resume_select_flag) else $error("resume flag lost");
   chk_resume_clear: assert property (@(posedge i_clock) disable iff (i_rst)
      (flag_clr && !flag_set) |=> !o_resume_select_flag) else $error("resume flag not cleared");
   chk_echo_load: assert property (@(posedge i_clock) disable iff (i_rst)
      (byte_done && state == P_RXDATA) |=> (state == P_ECHO && tx_sh == $past(rx_byte)))
      else $error("echo byte wrong");
   chk_ctl_fields: assert property (@(posedge i_clock) disable iff (i_rst)
      (o_control == 8'h4c) |-> (o_wiper_number_field == 2'd0 && o_charge_pump_on_bit))
      else $error("control fields wrong");
   chk_bad_release: assert property (@(posedge i_clock) disable iff (i_rst)
      (byte_done && state == P_RXREL && rx_byte != pot_link_pkg::FN_RELEASE)
      |=> (state == P_STATUS && status_bit && $stable(o_wiper))) else $error("bad release committed");
   chk_wiper_inc: assert property (@(posedge i_clock) disable iff (i_rst)
      (byte_done && state == P_FUNC && rx_byte == pot_link_pkg::FN_INC && o_wiper != 8'hff)
      |=> (o_wiper == $past(o_wiper) + 8'h01 && tx_sh == o_wiper)) else $error("increment wrong");
   chk_wiper_dec: assert property (@(posedge i_clock) disable iff (i_rst)
      (byte_done && state == P_FUNC && rx_byte == pot_link_pkg::FN_DEC && o_wiper != 8'h00)
      |=> (o_wiper == $past(o_wiper) - 8'h01 && tx_sh == o_wiper)) else $error("decrement wrong");
   chk_long_reset: assert property (@(posedge i_clock) disable iff (i_rst)
      (rst_det && low_cnt >= 20'(EXIT_CYC) && !set_fast) |=> !o_fast_mode) else $error("fast kept");
   chk_read_zero: assert property (@(posedge i_clock) disable iff (i_rst)
      (link == L_IDLE && fall && tx_mode && tx_bit && !rst_det) |=> !drive) else $error("one driven");
endmodule

// file: sim/line_master.sv
// Purpose: behavioural master for the single-wire potentiometer link
// Assumes: 8 ns clock, slave built with the shortened slot counts
// Notes: the line has a pull-up, so whatever nobody pulls reads high
`timescale 1ns/100ps
module line_master (
   // clock
   input wire logic i_clock,
   // line
   input wire logic i_line,
   output logic o_pull_low
);
   bit fast = 1'b0;
   initial o_pull_low = 1'b0;
   task automatic hold(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask
   task automatic line_reset(input int low, output logic seen);
      o_pull_low = 1'b1;
      hold(low);
      o_pull_low = 1'b0;
      hold(fast ? 4 : 10);
      seen = i_line;
      hold(fast ? 16 : 40);
      seen = seen & ~i_line;
      hold(fast ? 30 : 120);
   endtask
   // master opens each slot, idles high
   task automatic slot(input logic wbit, output logic rbit);
      o_pull_low = 1'b1;
      hold(wbit ? (fast ? 1 : 2) : (fast ? 18 : 50));
      o_pull_low = 1'b0;
      hold(wbit ? (fast ? 6 : 13) : 1);
      rbit = i_line;
      hold(fast ? 10 : 30);
   endtask
   task automatic xfer(input logic [7:0] wr, output logic [7:0] rd);
      for (int i = 0; i < 8; i++) begin
         slot(wr[i], rd[i]);
      end
   endtask
endmodule

// file: sim/single_wire_pot_slave_bench.sv
// Purpose: self-checking bench for the single-wire potentiometer slave
// Assumes: shortened line counts, master model drives the line
// Notes: drain side stalls until the ninth commit is refused
`timescale 1ns/100ps
module single_wire_pot_slave_bench;
   typedef struct {
      logic [7:0] fn;
      logic [7:0] arg;
      logic fresh;
      logic [7:0] w;
   } row_t;
   localparam logic [63:0] ID = 64'h5a3c_0f96_1e2d_4b01; // arbitrary value
   // shortened line counts, master model timing is built around them
   localparam int RST_CYC = 600;
   localparam int RST_FAST_CYC = 120;
   localparam int EXIT_CYC = 600;
   localparam int PWAIT_CYC = 20;
   localparam int PWAIT_FAST_CYC = 8;
   localparam int PLOW_CYC = 60;
   localparam int PLOW_FAST_CYC = 20;
   localparam int SLOT_CYC = 30;
   localparam int SLOT_FAST_CYC = 10;
   logic clock;
   logic line_out;
   logic rst;
   logic pos_ready;
   logic pull_low;
   logic oe_n;
   logic [7:0] wiper;
   logic [7:0] control;
   logic [7:0] pos_data;
   logic [7:0] rd;
   logic [7:0] exp_w;
   logic [1:0] wnum;
   logic pump;
   logic fast;
   logic flag;
   logic pos_valid;
   logic [7:0] fq[$];
   int failures = 0;
   int compares = 0;
   int n;
   // command, argument, new transaction, wiper afterwards
   row_t rows[9] = '{
      '{8'h55, 8'h4c, 1'b1, 8'h00}, '{8'h0f, 8'h7f, 1'b1, 8'h7f}, '{8'hc3, 8'h00, 1'b1, 8'h80},
      '{8'hc3, 8'h00, 1'b0, 8'h81}, '{8'h99, 8'h00, 1'b0, 8'h80}, '{8'h0f, 8'h00, 1'b1, 8'h00},
      '{8'h99, 8'h00, 1'b1, 8'h00}, '{8'h0f, 8'hff, 1'b1, 8'hff}, '{8'hc3, 8'h00, 1'b1, 8'hff}};
   wire line = ~pull_low & oe_n;
   single_wire_pot_slave #(.ROM_ID(ID), .RST_CYC(RST_CYC), .RST_FAST_CYC(RST_FAST_CYC), .EXIT_CYC(EXIT_CYC),
      .PWAIT_CYC(PWAIT_CYC), .PWAIT_FAST_CYC(PWAIT_FAST_CYC), .PLOW_CYC(PLOW_CYC), .PLOW_FAST_CYC(PLOW_FAST_CYC),
      .SLOT_CYC(SLOT_CYC), .SLOT_FAST_CYC(SLOT_FAST_CYC)) dut (
      .i_clock(clock), .i_rst(rst), .i_line(line), .o_line_out(line_out), .o_line_oe_n(oe_n), .o_wiper(wiper),
      .o_control(control), .o_wiper_number_field(wnum), .o_charge_pump_on_bit(pump), .o_fast_mode(fast),
      .o_resume_select_flag(flag), .o_pos_valid(pos_valid), .o_pos_data(pos_data), .i_pos_ready(pos_ready));
   line_master mst (.i_clock(clock), .i_line(line), .o_pull_low(pull_low));
   task automatic hold(input int c);
      repeat (c) @(posedge clock);
      #1;
   endtask
   task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("FAIL %0t %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask
   task automatic finish_test();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic open_txn(input logic [7:0] rom, input int low);
      logic seen;
      mst.line_reset(low, seen);
      check(seen, 1'b1, "presence");
      mst.xfer(rom, rd);
   endtask
   task automatic write_fn(input logic [7:0] fn, input logic [7:0] arg, input logic [7:0] st);
      mst.xfer(fn, rd);
      mst.xfer(arg, rd);
      mst.xfer(8'hff, rd);
      check(rd, arg, "echo");
      check(wiper, exp_w, "early update");
      mst.xfer(pot_link_pkg::FN_RELEASE, rd);
      mst.xfer(8'hff, rd);
      check(rd, st, "release status");
   endtask
   task automatic step(input logic [7:0] fn, input logic [7:0] w);
      mst.xfer(fn, rd);
      mst.xfer(8'hff, rd);
      check(rd, w, "stepped position");
   endtask
   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end
   initial begin
      repeat (99000) @(posedge clock);
      failures++;
      $display("FAIL %0t run hung", $time);
      finish_test();
   end
   initial begin
      rst = 1'b1;
      pos_ready = 1'b0;
      exp_w = 8'h00;
      hold(4);
      check({oe_n, line_out, wiper, control, fast, flag, pos_valid}, {1'b1, 20'h0}, "reset values");
      rst = 1'b0;
      hold(2);
      foreach (rows[k]) begin
         if (rows[k].fresh)
            open_txn(pot_link_pkg::ROM_SKIP, 700);
         if (rows[k].fn == 8'hc3 || rows[k].fn == 8'h99)
            step(rows[k].fn, rows[k].w);
         else
            write_fn(rows[k].fn, rows[k].arg, 8'h00);
         if (rows[k].fn == 8'h0f)
            fq.push_back(rows[k].arg);
         exp_w = rows[k].w;
         check(wiper, exp_w, "wiper");
      end
      check({control, wnum, pump, flag, fast}, {8'h4c, 2'b00, 1'b1, 2'b00}, "control");
      // five more commits fill the fifo, the sixth is refused
      for (int i = 0; i < 6; i++) begin
         open_txn(pot_link_pkg::ROM_SKIP, 700);
         write_fn(pot_link_pkg::FN_WRITE_POS, 8'h10 + 8'(i), (i < 5) ? 8'h00 : 8'hff);
         if (i < 5)
            fq.push_back(8'h10 + 8'(i));
         exp_w = (i < 5) ? 8'h10 + 8'(i) : exp_w;
         check(wiper, exp_w, "wiper after release");
      end
      while (fq.size() > 0) begin
         n = 0;
         while (pos_valid !== 1'b1 && n < 20) begin
            hold(1);
            n++;
         end
         hold(2);
         check({pos_valid, pos_data}, {1'b1, fq.pop_front()}, "fifo head");
         pos_ready = 1'b1;
         hold(1);
         pos_ready = 1'b0;
         hold(2);
      end
      check(pos_valid, 1'b0, "fifo drained");
      open_txn(pot_link_pkg::ROM_SKIP, 700);
      write_fn(pot_link_pkg::FN_WRITE_CTL, 8'h41, 8'h00);
      check({control, wnum, pump}, {8'h41, 2'b01, 1'b1}, "control fields");
      open_txn(pot_link_pkg::ROM_SKIP, 700);
      mst.xfer(pot_link_pkg::FN_WRITE_POS, rd);
      mst.xfer(8'h33, rd);
      mst.xfer(8'hff, rd);
      check(rd, 8'h33, "echo before bad code");
      mst.xfer(8'h69, rd);
      mst.xfer(8'hff, rd);
      check(rd, 8'hff, "bad release status");
      check(wiper, exp_w, "wiper after bad code");
      open_txn(pot_link_pkg::ROM_MATCH, 700);
      for (int b = 0; b < 8; b++) begin
         mst.xfer(ID[8*b +: 8], rd);
      end
      check(flag, 1'b1, "flag after match");
      for (int r = 0; r < 2; r++) begin
         open_txn(pot_link_pkg::ROM_RESUME, 700);
         exp_w = exp_w + 8'h01;
         step(pot_link_pkg::FN_INC, exp_w);
      end
      open_txn(pot_link_pkg::ROM_MATCH, 700);
      for (int b = 0; b < 8; b++) begin
         mst.xfer(ID[8*b +: 8] ^ 8'h01, rd);
      end
      check(flag, 1'b0, "flag after other match");
      open_txn(pot_link_pkg::ROM_RESUME, 700);
      step(pot_link_pkg::FN_INC, 8'hff);
      check(wiper, exp_w, "silent device");
      open_txn(pot_link_pkg::ROM_FAST_SKIP, 700);
      check(fast, 1'b1, "fast entered");
      mst.fast = 1'b1;
      open_txn(pot_link_pkg::ROM_SKIP, 200);
      check(fast, 1'b1, "short reset");
      exp_w = exp_w - 8'h01;
      step(pot_link_pkg::FN_DEC, exp_w);
      mst.fast = 1'b0;
      open_txn(pot_link_pkg::ROM_SKIP, 700);
      check(fast, 1'b0, "long reset");
      exp_w = exp_w + 8'h01;
      step(pot_link_pkg::FN_INC, exp_w);
      finish_test();
   end
endmodule
